// file: pfr_defines.svh
// Constants for the PWM fault recovery control block.
// Assumes a 24-bit byte address space on the AXI4-Lite register bus.
`ifndef PFR_DEFINES_SVH
`define PFR_DEFINES_SVH

// Bus geometry
`define PFR_ADDR_W        24
`define PFR_DATA_W        32

// Register byte addresses
`define PFR_CFG_ADDR      24'hffe388
`define PFR_STATUS_ADDR   24'hffe38c
`define PFR_MASK_ADDR     24'hffe390

// Reset values
`define PFR_CFG_RST       8'h00
`define PFR_MASK_RST      4'hf

// Field positions in the configuration register
`define PFR_FIN_RST_BIT   0
`define PFR_FIN_IRQ_BIT   1
`define PFR_CMP0_RST_BIT  2
`define PFR_CMP0_IRQ_BIT  3
`define PFR_CMP1_RST_BIT  4
`define PFR_CMP1_IRQ_BIT  5
`define PFR_DBG_RST_BIT   6

// Fault source positions in status, mask and source vectors
`define PFR_SRC_FIN       0
`define PFR_SRC_CMP0      1
`define PFR_SRC_CMP1      2
`define PFR_SRC_DBG       3
`define PFR_LIVE_BIT      4

// AXI responses
`define PFR_RESP_OKAY     2'h0
`define PFR_RESP_SLVERR   2'h2

`endif

// file: pfr_pkg.sv
// Types for the PWM fault recovery control block.
// Assumes pfr_defines.svh is on the include path.
`include "pfr_defines.svh"

package pfr_pkg;

  // Recovery state of the PWM outputs
  typedef enum logic {
    PFR_RUN,
    PFR_TRIPPED
  } pfr_mode_t;

  // AXI4-Lite master to slave
  typedef struct packed {
    logic                    awvalid;
    logic [`PFR_ADDR_W-1:0]  awaddr;
    logic                    wvalid;
    logic [`PFR_DATA_W-1:0]  wdata;
    logic [3:0]              wstrb;
    logic                    bready;
    logic                    arvalid;
    logic [`PFR_ADDR_W-1:0]  araddr;
    logic                    rready;
  } pfr_axi_req_t;

  // AXI4-Lite slave to master
  typedef struct packed {
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [`PFR_DATA_W-1:0]  rdata;
    logic [1:0]              rresp;
  } pfr_axi_rsp_t;

  // Whole state of the block
  typedef struct packed {
    pfr_axi_rsp_t            axi;
    logic                    aw_held;
    logic [`PFR_ADDR_W-1:0]  aw_addr;
    logic                    w_held;
    logic [7:0]              w_data;
    logic                    w_lane0;
    logic [7:0]              cfg;
    logic [3:0]              flags;
    logic [3:0]              mask;
    logic [3:0]              src_prev;
    logic [3:0]              tripped;
    pfr_mode_t               mode;
    logic                    out_en;
    logic                    irq;
  } pfr_state_t;

endpackage : pfr_pkg

// file: pfr_ctrl.sv
// PWM fault recovery control with an AXI4-Lite register slave.
// Assumes fault inputs, reload and period pulses are synchronous to mclk_i.
//
// Notes on behaviour
// RL1: Debug auto recovery waits for next period.
// RL2: Debug software recovery needs clear flags, reload.
// RL3: Comparator 1 enable gates its interrupt.
// RL4: Comparator 1 restart: auto or software recovery.
// RL5: Comparator 0 enable gates its interrupt.
// RL6: Comparator 0 restart: auto or software recovery.
// RL7: Configuration writes only while PWM disabled.
// RL8: Fault input bits behave like comparator bits.
`include "pfr_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module pfr_ctrl (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 reset_n_i,
  // Register bus
  input  wire pfr_pkg::pfr_axi_req_t s_axi_i,
  output var  pfr_pkg::pfr_axi_rsp_t s_axi_o,
  // PWM side
  input  wire logic [3:0]           fault_src_i,
  input  wire logic                 pwm_run_enable_i,
  input  wire logic                 period_start_i,
  input  wire logic                 pwm_reload_i,
  output logic                      pwm_out_enable_o,
  output logic                      irq_o
);
  import pfr_pkg::*;

  pfr_state_t st_r;
  pfr_state_t st_nxt;

  // Restart selectors per source, one means software recovery
  function automatic logic [3:0] restart_sel(input logic [7:0] cfg);
    restart_sel = {cfg[`PFR_DBG_RST_BIT], cfg[`PFR_CMP1_RST_BIT],
                   cfg[`PFR_CMP0_RST_BIT], cfg[`PFR_FIN_RST_BIT]};
  endfunction

  // Interrupt enables per source; debug halt has none
  function automatic logic [3:0] irq_sel(input logic [7:0] cfg);
    irq_sel = {1'b0, cfg[`PFR_CMP1_IRQ_BIT],
               cfg[`PFR_CMP0_IRQ_BIT], cfg[`PFR_FIN_IRQ_BIT]};
  endfunction

  logic [3:0] rs_sel;
  logic [3:0] rise;
  logic       do_wr;
  logic       wr_hit;
  logic       rd_hit;
  logic [7:0] wbyte;

  // Next state of bus slave, registers and recovery logic
  always_comb begin
    st_nxt = st_r;
    rs_sel = restart_sel(st_r.cfg);
    rise   = fault_src_i & ~st_r.src_prev;
    wbyte  = st_r.w_data;
    do_wr  = 1'b0;
    wr_hit = 1'b0;
    rd_hit = 1'b0;
    st_nxt.src_prev = fault_src_i;

    // Write address and data are taken in either order
    if (s_axi_i.awvalid && st_r.axi.awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = s_axi_i.awaddr;
    end
    if (s_axi_i.wvalid && st_r.axi.wready) begin
      st_nxt.w_held  = 1'b1;
      st_nxt.w_data  = s_axi_i.wdata[7:0];
      st_nxt.w_lane0 = s_axi_i.wstrb[0];
    end
    if (st_r.axi.bvalid && s_axi_i.bready) begin
      st_nxt.axi.bvalid = 1'b0;
    end

    // Complete a write once both halves are held
    if (st_r.aw_held && st_r.w_held && !st_r.axi.bvalid) begin
      do_wr          = st_r.w_lane0;
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.axi.bvalid = 1'b1;
      wr_hit = (st_r.aw_addr == `PFR_CFG_ADDR) ||
               (st_r.aw_addr == `PFR_STATUS_ADDR) ||
               (st_r.aw_addr == `PFR_MASK_ADDR);
      st_nxt.axi.bresp = wr_hit ? `PFR_RESP_OKAY : `PFR_RESP_SLVERR;
    end

    // Configuration accepts writes only while the PWM is stopped
    if (do_wr && st_r.aw_addr == `PFR_CFG_ADDR && !pwm_run_enable_i) begin // [RL7]
      st_nxt.cfg = {1'b0, wbyte[6:0]};
    end
    if (do_wr && st_r.aw_addr == `PFR_MASK_ADDR) begin
      st_nxt.mask = wbyte[3:0];
    end

    // Sticky fault flags: set on assertion, write one to clear, set wins
    if (do_wr && st_r.aw_addr == `PFR_STATUS_ADDR) begin
      st_nxt.flags = st_r.flags & ~wbyte[3:0];
    end
    st_nxt.flags = st_nxt.flags | rise;

    // Read channel
    if (st_r.axi.rvalid && s_axi_i.rready) begin
      st_nxt.axi.rvalid = 1'b0;
    end
    if (s_axi_i.arvalid && st_r.axi.arready) begin
      rd_hit = 1'b1;
      st_nxt.axi.rvalid = 1'b1;
      st_nxt.axi.rresp  = `PFR_RESP_OKAY;
      st_nxt.axi.rdata  = '0;
      case (s_axi_i.araddr)
        `PFR_CFG_ADDR: begin
          st_nxt.axi.rdata[7:0] = st_r.cfg;
        end
        `PFR_STATUS_ADDR: begin
          st_nxt.axi.rdata[3:0] = st_r.flags;
          st_nxt.axi.rdata[`PFR_LIVE_BIT] = st_r.out_en;
        end
        `PFR_MASK_ADDR: begin
          st_nxt.axi.rdata[3:0] = st_r.mask;
        end
        default: begin
          st_nxt.axi.rresp = `PFR_RESP_SLVERR;
        end
      endcase
    end

    // Fault recovery sequencing
    case (st_r.mode)
      PFR_RUN: begin
        st_nxt.tripped = 4'h0;
        if (|fault_src_i) begin
          st_nxt.mode    = PFR_TRIPPED;
          st_nxt.tripped = fault_src_i;
        end
      end
      PFR_TRIPPED: begin
        st_nxt.tripped = st_r.tripped | fault_src_i;
        if (|fault_src_i) begin
          st_nxt.mode = PFR_TRIPPED;
        end else if (|(st_r.tripped & rs_sel)) begin
          // Software recovery: flags cleared, then a reload
          if (st_r.flags == 4'h0 && pwm_reload_i) begin // [RL2] [RL4] [RL6] [RL8]
            st_nxt.mode = PFR_RUN;
          end
        end else if (st_r.tripped[`PFR_SRC_DBG]) begin
          // Automatic debug recovery waits for the next period
          if (period_start_i) begin // [RL1]
            st_nxt.mode = PFR_RUN;
          end
        end else begin
          st_nxt.mode = PFR_RUN; // [RL4] [RL6] [RL8]
        end
      end
      default: begin
        st_nxt.mode = PFR_TRIPPED;
      end
    endcase
    st_nxt.out_en = (st_nxt.mode == PFR_RUN);

    // Interrupt from enabled, unmasked sticky flags
    st_nxt.irq = |(st_nxt.flags & st_nxt.mask & irq_sel(st_nxt.cfg)); // [RL3] [RL5] [RL8]

    // Ready lines: one write and one read outstanding at most
    st_nxt.axi.awready = !st_nxt.aw_held && !st_nxt.axi.bvalid;
    st_nxt.axi.wready  = !st_nxt.w_held && !st_nxt.axi.bvalid;
    st_nxt.axi.arready = !st_nxt.axi.rvalid && !rd_hit;
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      st_r          <= '0;
      st_r.cfg      <= `PFR_CFG_RST;
      st_r.mask     <= `PFR_MASK_RST;
      st_r.mode     <= PFR_RUN;
      st_r.out_en   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign s_axi_o          = st_r.axi;
  assign pwm_out_enable_o = st_r.out_en;
  assign irq_o            = st_r.irq;

  // Checks on the configuration lock, recovery and interrupt behaviour
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  cfg_locked_a: // [RL7]
    assert property (pwm_run_enable_i |=> $stable(st_r.cfg))
      else $error("configuration changed while PWM enabled");

  fault_cuts_a: // [RL6]
    assert property (|fault_src_i |=> !pwm_out_enable_o)
      else $error("outputs kept while a fault is asserted");

  auto_resume_a: // [RL4]
    assert property ((st_r.mode == PFR_TRIPPED) && (fault_src_i == 4'h0) &&
                     ((st_r.tripped & restart_sel(st_r.cfg)) == 4'h0) &&
                     !st_r.tripped[`PFR_SRC_DBG] |=> pwm_out_enable_o)
      else $error("automatic recovery did not resume outputs");

  dbg_period_a: // [RL1]
    assert property ((st_r.mode == PFR_TRIPPED) && (fault_src_i == 4'h0) &&
                     ((st_r.tripped & restart_sel(st_r.cfg)) == 4'h0) &&
                     st_r.tripped[`PFR_SRC_DBG] |=>
                     (pwm_out_enable_o == $past(period_start_i)))
      else $error("debug recovery not tied to period start");

  sw_wait_a: // [RL2]
    assert property ((st_r.mode == PFR_TRIPPED) &&
                     (|(st_r.tripped & restart_sel(st_r.cfg))) &&
                     (!pwm_reload_i || st_r.flags != 4'h0) |=> !pwm_out_enable_o)
      else $error("software recovery resumed too early");

  cmp1_irq_a: // [RL3]
    assert property ($rose(st_r.flags[`PFR_SRC_CMP1]) && st_r.cfg[`PFR_CMP1_IRQ_BIT] &&
                     st_r.mask[`PFR_SRC_CMP1] |-> irq_o)
      else $error("comparator 1 interrupt missing");

  cmp0_irq_a: // [RL5]
    assert property ($rose(st_r.flags[`PFR_SRC_CMP0]) && st_r.cfg[`PFR_CMP0_IRQ_BIT] &&
                     st_r.mask[`PFR_SRC_CMP0] |-> irq_o)
      else $error("comparator 0 interrupt missing");

  fin_irq_a: // [RL8]
    assert property ($rose(st_r.flags[`PFR_SRC_FIN]) && st_r.cfg[`PFR_FIN_IRQ_BIT] &&
                     st_r.mask[`PFR_SRC_FIN] |-> irq_o)
      else $error("fault input interrupt missing");

  irq_gated_a: // [RL3]
    assert property (((st_r.flags & st_r.mask & irq_sel(st_r.cfg)) == 4'h0) |-> !irq_o)
      else $error("interrupt raised while all requests disabled");

endmodule // pfr_ctrl

`default_nettype wire

// file: pfr_far_model.sv
// Far-side model: fault sources, PWM period ticks and reload pulses.
// Assumes the bench commands faults and reloads in step with mclk_i.
`timescale 1ns/1ns
`default_nettype none
module pfr_far_model (
  // Clock and commands
  input  wire logic       mclk_i,
  input  wire logic [3:0] fault_cmd_i,
  input  wire logic       reload_req_i,
  // Toward the block
  output logic [3:0]      fault_src_o,
  output logic            period_start_o,
  output logic            pwm_reload_o
);
  logic [2:0] tick_r = 3'h0;
  // Faults follow the command a cycle late; a period starts every eight cycles
  always @(posedge mclk_i) begin
    tick_r         <= tick_r + 3'h1;
    period_start_o <= (tick_r == 3'h7);
    fault_src_o    <= fault_cmd_i;
    pwm_reload_o   <= reload_req_i;
  end
endmodule // pfr_far_model
`default_nettype wire

// file: tb_pwm_fault_recovery_control.sv
// Self-checking bench for the fault recovery block.
// Assumes pfr_pkg, pfr_ctrl and pfr_far_model are compiled first.
`include "pfr_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_pwm_fault_recovery_control;
  import pfr_pkg::*;
  logic         mclk, reset_n, run_en, reload_req, period, reload, oe, irq;
  logic [3:0]   fault_cmd, src;
  logic [31:0]  rdata;
  logic [1:0]   resp;
  pfr_axi_req_t req;
  pfr_axi_rsp_t rsp;
  int           failures, check_count;

  pfr_ctrl DUT (.mclk_i(mclk), .reset_n_i(reset_n), .s_axi_i(req), .s_axi_o(rsp),
    .fault_src_i(src), .pwm_run_enable_i(run_en), .period_start_i(period),
    .pwm_reload_i(reload), .pwm_out_enable_o(oe), .irq_o(irq));
  pfr_far_model far (.mclk_i(mclk), .fault_cmd_i(fault_cmd), .reload_req_i(reload_req),
    .fault_src_o(src), .period_start_o(period), .pwm_reload_o(reload));

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Bus write; each channel is released at the edge that takes it
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    logic aw_t, w_t, done;
    int n;
    done = 1'b0;
    n = 0;
    req.awaddr  <= a;
    req.wdata   <= d;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    while (!done && n < 50) begin
      @(negedge mclk);
      aw_t = req.awvalid & rsp.awready;
      w_t = req.wvalid & rsp.wready;
      done = rsp.bvalid;
      resp = rsp.bresp;
      n++;
      @(posedge mclk);
      if (aw_t) req.awvalid <= 1'b0;
      if (w_t) req.wvalid <= 1'b0;
    end
    // A write response that never comes counts as a mismatch
    if (!done) begin
      failures++;
      $display("mismatch at %0t ns: no write response", $time);
    end
    req.bready <= 1'b0;
    @(posedge mclk);
  endtask

  // Bus read; data and response are kept in rdata and resp
  task automatic rd(input logic [23:0] a);
    logic ar_t, done;
    int n;
    done = 1'b0;
    n = 0;
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    while (!done && n < 50) begin
      @(negedge mclk);
      ar_t = req.arvalid & rsp.arready;
      done = rsp.rvalid;
      rdata = rsp.rdata;
      resp = rsp.rresp;
      n++;
      @(posedge mclk);
      if (ar_t) req.arvalid <= 1'b0;
    end
    // A read response that never comes counts as a mismatch
    if (!done) begin
      failures++;
      $display("mismatch at %0t ns: no read response", $time);
    end
    req.rready <= 1'b0;
    @(posedge mclk);
  endtask

  // Check output enable and interrupt where both are settled
  task automatic chk_pins(input logic oe_exp, input logic irq_exp);
    @(negedge mclk);
    chk({30'h0, oe, irq}, {30'h0, oe_exp, irq_exp});
    @(posedge mclk);
  endtask

  task automatic reload_pulse();
    reload_req <= 1'b1;
    @(posedge mclk);
    reload_req <= 1'b0;
    @(posedge mclk);
  endtask

  // Trip one source, release it just after a period tick, follow recovery
  task automatic trip(input int s, input logic sel);
    wr(`PFR_CFG_ADDR, {30'h0, sel, sel} << (2 * s));
    fault_cmd[s] <= 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    while (!period) @(negedge mclk);
    @(posedge mclk);
    fault_cmd[s] <= 1'b0;
    repeat (3) @(posedge mclk);
    chk_pins(!sel && s != 3, sel && s != 3);
    repeat (4) @(posedge mclk);
    chk_pins(!sel, sel && s != 3);
    if (sel) begin
      rd(`PFR_STATUS_ADDR);
      chk(rdata, 32'h1 << s);
      reload_pulse();
      chk_pins(1'b0, s != 3);
      wr(`PFR_MASK_ADDR, 32'h0);
      chk_pins(1'b0, 1'b0);
      wr(`PFR_MASK_ADDR, 32'hf);
    end
    wr(`PFR_STATUS_ADDR, 32'hf);
    if (sel) reload_pulse();
    chk_pins(1'b1, 1'b0);
  endtask

  // Clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    give_verdict();
  end

  // Main sequence
  initial begin
    reset_n = 1'b0;
    run_en = 1'b0;
    reload_req = 1'b0;
    fault_cmd = 4'h0;
    req = '0;
    req.wstrb = 4'hf;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(`PFR_CFG_ADDR);
    chk(rdata, 32'h0);
    rd(`PFR_MASK_ADDR);
    chk(rdata, 32'hf);
    rd(`PFR_STATUS_ADDR);
    chk(rdata, 32'h10);
    rd(24'hffe394);
    chk({30'h0, resp}, {30'h0, `PFR_RESP_SLVERR});
    run_en <= 1'b1;
    wr(`PFR_CFG_ADDR, 32'h7f);
    chk({30'h0, resp}, {30'h0, `PFR_RESP_OKAY});
    rd(`PFR_CFG_ADDR);
    chk(rdata, 32'h0);
    run_en <= 1'b0;
    wr(`PFR_CFG_ADDR, 32'hff);
    rd(`PFR_CFG_ADDR);
    chk(rdata, 32'h7f);
    for (int s = 0; s < 4; s++) begin
      trip(s, 1'b0);
      trip(s, 1'b1);
    end
    give_verdict();
  end
endmodule // tb_pwm_fault_recovery_control
`default_nettype wire
